// ### dbs_bank_props_properties.sv
// Timing and legality properties of the bank tracker
`timescale 1ns/1ns
`include "dbs_defines.vh"
module dbs_bank_props #(
	parameter NBANK = 8,
	parameter BA_W  = 3
) (
	input wire              core_clk,
	input wire              rstn,
	input wire              cke,
	input wire              cs_n,
	input wire              ras_n,
	input wire              cas_n,
	input wire              we_n,
	input wire [BA_W-1:0]   ba,
	input wire              a10,
	input wire [NBANK*4-1:0] bank_state_r,
	input wire              cmd_valid_r,
	input wire              cmd_illegal_r,
	input wire [BA_W-1:0]   mode_reg_sel_r,
	input wire              mode_load_r
);
	// Bank one state and decoded strobes
	wire [3:0] st1 = bank_state_r[7:4];
	wire [2:0] op  = {ras_n, cas_n, we_n};
	wire       b1  = !cs_n && ba == 1;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	property p_desel;
		cs_n |=> !cmd_valid_r && !cmd_illegal_r;
	endproperty
	a_desel: assert property (p_desel) else $error("deselect acted");
	property p_nop;
		!cs_n && op == `DBS_CMD_NOP |=> !cmd_valid_r && !cmd_illegal_r;
	endproperty
	a_nop: assert property (p_nop) else $error("nop acted");
	property p_cke;
		!cke |=> !cmd_valid_r && !cmd_illegal_r;
	endproperty
	a_cke: assert property (p_cke) else $error("cke low acted");
	property p_act;
		b1 && op == `DBS_CMD_ACT ##1 cmd_valid_r |-> st1 == 4'h1;
	endproperty
	a_act: assert property (p_act) else $error("no activation");
	property p_row;
		st1 == 4'h1 && $past(st1) != 4'h1 |-> ##[1:3] st1 == 4'h2;
	endproperty
	a_row: assert property (p_row) else $error("row late");
	property p_rd;
		b1 && op == `DBS_CMD_RD && st1 == 4'h2 ##1 cmd_valid_r
			|-> st1 == ($past(a10) ? 4'h5 : 4'h3);
	endproperty
	a_rd: assert property (p_rd) else $error("read state");
	property p_pre;
		st1 == 4'h7 && $past(st1) != 4'h7 |-> ##[1:3] st1 == 4'h0;
	endproperty
	a_pre: assert property (p_pre) else $error("precharge late");
	property p_ref;
		st1 == 4'h8 && $past(st1) != 4'h8 |-> ##[3:5] st1 == 4'h0;
	endproperty
	a_ref: assert property (p_ref) else $error("refresh late");
	property p_lmr;
		!cs_n && op == `DBS_CMD_LMR ##1 cmd_valid_r
			|-> mode_load_r && mode_reg_sel_r == $past(ba);
	endproperty
	a_lmr: assert property (p_lmr) else $error("mode load");
	// Main scenarios reached
	c_valid: cover property (cmd_valid_r);
	c_bad: cover property (cmd_illegal_r);
	c_mode: cover property (mode_load_r);
endmodule
bind dbs_bank_tracker dbs_bank_props #(.NBANK(NBANK), .BA_W(BA_W)) u_props (.*);

// ### dbs_bank_tracker.v
// Per-bank DDR2 command legality and state tracker
// Behaviour
// - Rules apply only with clock enable high two cycles, after exit delay.
// - Deselect starts no command; ongoing operations continue.
// - No-operation has no effect; ongoing operations continue.
// - Idle after precharge time and finished read (code ends precharge on precharge time alone, burst not checked); only idle accepts ACTIVATE.
// - Row active once row opened and activate delay elapsed.
// - Row active accepts READ, WRITE or PRECHARGE.
// - READ and WRITE may carry auto precharge or not.
// - Read state accepts new READ or PRECHARGE until burst ends.
// - Write state accepts READ, new WRITE or PRECHARGE.
// - Precharge period lasts precharge time, then bank idle.
// - READ with auto precharge ends after burst plus precharge time, bank idle.
// - WRITE with auto precharge ends after burst plus precharge time, bank idle.
// - Activation lasts activate-to-column delay, then row active.
// - Refresh lasts refresh cycle time, then all banks idle.
// - Mode load lasts mode set delay, then all banks idle.
// - Precharge all lasts precharge time, then every bank idle.
// - Commands decode from select, strobes and clock enable at the edge.
// - Bank address picks the bank, or the mode register for LOAD MODE.
`timescale 1ns/1ns
`include "dbs_defines.vh"
module dbs_bank_tracker #(
	parameter NBANK     = 8,
	parameter BA_W      = 3,
	parameter TRP_CK    = `DBS_CYC(`DBS_TRP_PS),
	parameter ACTIVATE_TO_COLUMN_DELAY_CK   = `DBS_CYC(`DBS_ACTIVATE_TO_COLUMN_DELAY_PS),
	parameter REFRESH_CYCLE_TIME_CK   = `DBS_CYC(`DBS_REFRESH_CYCLE_TIME_PS),
	parameter MODE_SET_DELAY_CK   = `DBS_MODE_SET_DELAY_CK,
	parameter SELF_REFRESH_EXIT_DELAY_CK  = `DBS_CYC(`DBS_SELF_REFRESH_EXIT_DELAY_PS),
	parameter BURST_CK  = `DBS_BURST_CK
) (
	input  wire                  core_clk,
	input  wire                  rstn,
	input  wire                  cke,
	input  wire                  cs_n,
	input  wire                  ras_n,
	input  wire                  cas_n,
	input  wire                  we_n,
	input  wire [BA_W-1:0]       ba,
	input  wire                  a10,
	input  wire                  self_refresh_exit,
	output reg  [NBANK*4-1:0]    bank_state_r,
	output reg                   all_idle_r,
	output reg                   cmd_valid_r,
	output reg                   cmd_illegal_r,
	output reg  [BA_W-1:0]       mode_reg_sel_r,
	output reg                   mode_load_r
);

	localparam [`DBS_CNT_W-1:0] TRP_V   = TRP_CK[`DBS_CNT_W-1:0];
	localparam [`DBS_CNT_W-1:0] ACTIVATE_TO_COLUMN_DELAY_V  = ACTIVATE_TO_COLUMN_DELAY_CK[`DBS_CNT_W-1:0];
	localparam [`DBS_CNT_W-1:0] REFRESH_CYCLE_TIME_V  = REFRESH_CYCLE_TIME_CK[`DBS_CNT_W-1:0];
	localparam [`DBS_CNT_W-1:0] MODE_SET_DELAY_V  = MODE_SET_DELAY_CK[`DBS_CNT_W-1:0];
	localparam [`DBS_CNT_W-1:0] SELF_REFRESH_EXIT_DELAY_V = SELF_REFRESH_EXIT_DELAY_CK[`DBS_CNT_W-1:0];
	localparam [`DBS_CNT_W-1:0] BURST_V = BURST_CK[`DBS_CNT_W-1:0];
	localparam [`DBS_CNT_W-1:0] AP_V    = BURST_V + TRP_V;
	localparam [`DBS_CNT_W-1:0] ZERO    = {`DBS_CNT_W{1'b0}};
	localparam [`DBS_CNT_W-1:0] ONE     = {{(`DBS_CNT_W-1){1'b0}}, 1'b1};

	reg                         cke_prev_r;
	reg  [`DBS_CNT_W-1:0]       xs_cnt_r;
	reg  [NBANK*`DBS_CNT_W-1:0] cnt_r;
	reg  [NBANK*`DBS_CNT_W-1:0] brst_r;
	// Per-bank results gathered from the generate loop
	wire [NBANK*4-1:0]          st_nxt;
	wire [NBANK*`DBS_CNT_W-1:0] cnt_nxt;
	wire [NBANK*`DBS_CNT_W-1:0] brst_nxt;
	wire [NBANK-1:0]            ill_vec;
	wire [NBANK-1:0]            busy_vec;
	wire [NBANK-1:0]            glob_vec;
	wire                        ill_nxt;
	wire                        all_idle_nxt;
	wire                        glob_busy;

	// Command fields and qualifiers sampled at the rising edge
	wire [2:0] cmd     = {ras_n, cas_n, we_n};
	wire       cke_ok  = cke_prev_r & cke;
	wire       xs_done = (xs_cnt_r == ZERO);
	// Rules apply only with clock enable held and exit delay over
	wire       live    = cke_ok & xs_done;
	// Deselect and no-operation never count as commands
	wire       exe     = live & ~cs_n & (cmd != `DBS_CMD_NOP);

	// Command class decode shared by every bank
	wire       cmd_ref = (cmd == `DBS_CMD_REF);
	wire       cmd_lmr = (cmd == `DBS_CMD_LMR);
	wire       cmd_pre = (cmd == `DBS_CMD_PRE);
	wire       cmd_act = (cmd == `DBS_CMD_ACT);
	wire       cmd_rd  = (cmd == `DBS_CMD_RD);
	wire       cmd_wr  = (cmd == `DBS_CMD_WR);
	wire       cmd_col = cmd_rd | cmd_wr;
	wire       cmd_glb = cmd_ref | cmd_lmr;
	wire       cmd_bad = ~(cmd_glb | cmd_pre | cmd_act | cmd_col);

	// Clock enable history for the two-cycle check
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cke_prev_r <= 1'b0;
		end else begin
			cke_prev_r <= cke;
		end
	end

	// Self refresh exit delay blocks commands while it runs
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			xs_cnt_r <= ZERO;
		end else if (self_refresh_exit) begin
			xs_cnt_r <= SELF_REFRESH_EXIT_DELAY_V;
		end else if (xs_cnt_r != ZERO) begin
			xs_cnt_r <= xs_cnt_r - ONE;
		end
	end

	// Device-wide busy, illegal and idle summaries
	assign glob_busy    = |glob_vec;
	assign ill_nxt      = (|ill_vec) | (exe & cmd_bad);
	assign all_idle_nxt = ~|busy_vec;

	// One tracker per bank with its own interval counters
	genvar g;
	generate
		for (g = 0; g < NBANK; g = g + 1) begin : g_bank
			localparam integer    BANK_NUM = g;
			localparam [BA_W-1:0] BANK_ID  = BANK_NUM[BA_W-1:0];
			// Bank view and per-bank working values
			wire [3:0]            st_q;
			wire [`DBS_CNT_W-1:0] cnt_q;
			wire [`DBS_CNT_W-1:0] brst_q;
			wire                  sel;
			reg  [`DBS_CNT_W-1:0] cnt_dn;
			reg  [`DBS_CNT_W-1:0] brst_dn;
			reg  [3:0]            st_run;
			reg                   ill_glb;
			reg                   ill_pre;
			reg                   ill_act;
			reg                   ill_col;
			reg  [3:0]            st_new;
			reg  [`DBS_CNT_W-1:0] cnt_new;
			reg  [`DBS_CNT_W-1:0] brst_new;

			// Slices of this bank's registered state
			assign st_q   = bank_state_r[g*4 +: 4];
			assign cnt_q  = cnt_r[g*`DBS_CNT_W +: `DBS_CNT_W];
			assign brst_q = brst_r[g*`DBS_CNT_W +: `DBS_CNT_W];
			assign sel    = (ba == BANK_ID);

			// Interval and burst counters run down every cycle
			always @* begin
				cnt_dn  = cnt_q;
				brst_dn = brst_q;
				if (cnt_q != ZERO) begin
					cnt_dn = cnt_q - ONE;
				end
				if (brst_q != ZERO) begin
					brst_dn = brst_q - ONE;
				end
			end

			// Timed periods end into their follow-on state
			always @* begin
				st_run = st_q;
				case (st_q)
					`DBS_ST_ACTV: begin
						if (cnt_dn == ZERO) begin
							st_run = `DBS_ST_ROW;
						end
					end
					`DBS_ST_PRE: begin
						if (cnt_dn == ZERO) begin
							st_run = `DBS_ST_IDLE;
						end
					end
					`DBS_ST_RDAP, `DBS_ST_WRAP: begin
						if (cnt_dn == ZERO) begin
							st_run = `DBS_ST_IDLE;
						end
					end
					`DBS_ST_REF, `DBS_ST_LMR, `DBS_ST_PREALL: begin
						if (cnt_dn == ZERO) begin
							st_run = `DBS_ST_IDLE;
						end
					end
					`DBS_ST_READ, `DBS_ST_WRITE: begin
						if (brst_dn == ZERO) begin
							st_run = `DBS_ST_ROW;
						end
					end
					default: begin
						st_run = st_q;
					end
				endcase
			end

			// Device-wide commands need every bank idle
			always @* begin
				ill_glb = 1'b0;
				if (exe && cmd_glb) begin
					if (glob_busy || st_q != `DBS_ST_IDLE) begin
						ill_glb = 1'b1;
					end
				end
			end

			// Precharge refused in device-wide and uninterruptible periods
			always @* begin
				ill_pre = 1'b0;
				if (exe && cmd_pre && (a10 | sel)) begin
					if (glob_busy) begin
						ill_pre = 1'b1;
					end else if (st_q == `DBS_ST_ACTV ||
					             st_q == `DBS_ST_RDAP ||
					             st_q == `DBS_ST_WRAP) begin
						ill_pre = 1'b1;
					end
				end
			end

			// Activate accepted only from idle
			always @* begin
				ill_act = 1'b0;
				if (exe && cmd_act && sel) begin
					if (glob_busy || st_q != `DBS_ST_IDLE) begin
						ill_act = 1'b1;
					end
				end
			end

			// Column commands need an open row or a running burst
			always @* begin
				ill_col = 1'b0;
				if (exe && cmd_col && sel) begin
					case (st_q)
						`DBS_ST_ROW: begin
							ill_col = 1'b0;
						end
						`DBS_ST_READ: begin
							if (cmd_wr && brst_dn != ZERO) begin
								ill_col = 1'b1;
							end
						end
						`DBS_ST_WRITE: begin
							ill_col = 1'b0;
						end
						default: begin
							ill_col = 1'b1;
						end
					endcase
				end
			end

			// Command effect on state and counters, legal or not
			always @* begin
				st_new   = st_run;
				cnt_new  = cnt_dn;
				brst_new = brst_dn;
				if (exe && cmd_glb) begin
					if (cmd_ref) begin
						st_new  = `DBS_ST_REF;
						cnt_new = REFRESH_CYCLE_TIME_V;
					end else begin
						st_new  = `DBS_ST_LMR;
						cnt_new = MODE_SET_DELAY_V;
					end
					brst_new = ZERO;
				end
				if (exe && cmd_pre && (a10 | sel)) begin
					if (st_q != `DBS_ST_IDLE || a10) begin
						st_new  = a10 ? `DBS_ST_PREALL : `DBS_ST_PRE;
						cnt_new = TRP_V;
					end
				end
				if (exe && cmd_act && sel) begin
					st_new  = `DBS_ST_ACTV;
					cnt_new = ACTIVATE_TO_COLUMN_DELAY_V;
				end
				if (exe && cmd_col && sel) begin
					brst_new = BURST_V;
					if (a10) begin
						st_new  = cmd_rd ? `DBS_ST_RDAP : `DBS_ST_WRAP;
						cnt_new = AP_V;
					end else begin
						st_new = cmd_rd ? `DBS_ST_READ : `DBS_ST_WRITE;
					end
				end
			end

			// Results merged into the shared next-state words
			assign st_nxt[g*4 +: 4]                    = st_new;
			assign cnt_nxt[g*`DBS_CNT_W +: `DBS_CNT_W]  = cnt_new;
			assign brst_nxt[g*`DBS_CNT_W +: `DBS_CNT_W] = brst_new;
			assign ill_vec[g]  = ill_glb | ill_pre | ill_act | ill_col;
			assign busy_vec[g] = (st_new != `DBS_ST_IDLE);
			assign glob_vec[g] = (st_q == `DBS_ST_REF) ||
			                     (st_q == `DBS_ST_LMR) ||
			                     (st_q == `DBS_ST_PREALL);
		end
	endgenerate

	// Per-bank state and interval counters
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bank_state_r <= {NBANK{`DBS_ST_IDLE}};
			cnt_r        <= {NBANK*`DBS_CNT_W{1'b0}};
			brst_r       <= {NBANK*`DBS_CNT_W{1'b0}};
		end else begin
			bank_state_r <= st_nxt;
			cnt_r        <= cnt_nxt;
			brst_r       <= brst_nxt;
		end
	end

	// Command status pulses and idle summary
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			all_idle_r    <= 1'b1;
			cmd_valid_r   <= 1'b0;
			cmd_illegal_r <= 1'b0;
		end else begin
			all_idle_r    <= all_idle_nxt;
			cmd_valid_r   <= exe & ~ill_nxt;
			cmd_illegal_r <= exe & ill_nxt;
		end
	end

	// Mode register select captured on a load
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mode_reg_sel_r <= {BA_W{1'b0}};
			mode_load_r    <= 1'b0;
		end else begin
			mode_load_r <= exe & cmd_lmr;
			if (exe && cmd_lmr) begin
				mode_reg_sel_r <= ba;
			end
		end
	end

endmodule

// ### dbs_bank_tracker_test.sv
// Self-checking bench for the bank tracker
`timescale 1ns/1ns
`include "dbs_defines.vh"
module dbs_bank_tracker_test;
	reg         core_clk = 0;
	reg         rstn = 0;
	reg         self_refresh_exit = 0;
	wire        cke, cs_n, ras_n, cas_n, we_n, a10;
	wire [2:0]  ba, mode_reg_sel_r;
	wire [31:0] bank_state_r;
	wire        all_idle_r, cmd_valid_r, cmd_illegal_r, mode_load_r;
	integer     error_cnt = 0;
	integer     checks_done = 0;
	always #4 core_clk = ~core_clk;
	dbs_ctrl_model ctl (.*);
	dbs_bank_tracker #(.REFRESH_CYCLE_TIME_CK(4), .SELF_REFRESH_EXIT_DELAY_CK(3), .BURST_CK(4)) dut (.*);
	// Compare and count
	task chk(input [3:0] g, input [3:0] e);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("mismatch t=%0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	// Wait bounded for a bank state
	task wst(input [2:0] b, input [3:0] e);
		begin
			repeat (12) if (bank_state_r[b*4+:4] !== e) @(negedge core_clk);
			chk(bank_state_r[b*4+:4], e);
		end
	endtask
	task t_row;
		begin
			ctl.issue(`DBS_CMD_ACT, 1, 0);
			chk(cmd_valid_r, 1);
			chk(bank_state_r[7:4], 4'h1);
			wst(1, 4'h2);
			ctl.issue(`DBS_CMD_RD, 1, 0);
			chk(bank_state_r[7:4], 4'h3);
			wst(1, 4'h2);
			ctl.issue(`DBS_CMD_WR, 1, 1);
			chk(bank_state_r[7:4], 4'h6);
			wst(1, 4'h0);
			ctl.issue(`DBS_CMD_ACT, 1, 0);
			wst(1, 4'h2);
			ctl.issue(`DBS_CMD_PRE, 1, 0);
			chk(bank_state_r[7:4], 4'h7);
			wst(1, 4'h0);
			$display("row test done");
		end
	endtask
	task t_all;
		begin
			ctl.issue(`DBS_CMD_REF, 0, 0);
			chk(bank_state_r[3:0], 4'h8);
			wst(0, 4'h0);
			ctl.issue(`DBS_CMD_LMR, 5, 0);
			chk(mode_load_r, 1);
			chk(mode_reg_sel_r, 5);
			wst(0, 4'h0);
			ctl.issue(`DBS_CMD_ACT, 2, 0);
			wst(2, 4'h2);
			ctl.issue(`DBS_CMD_PRE, 2, 1);
			chk(bank_state_r[11:8], 4'hA);
			wst(2, 4'h0);
			chk(all_idle_r, 1);
			$display("all-bank test done");
		end
	endtask
	task t_seq;
		begin
			ctl.issue(`DBS_CMD_ACT, 5, 0);
			wst(5, 4'h2);
			ctl.issue(`DBS_CMD_RD, 5, 0);
			ctl.issue(`DBS_CMD_WR, 5, 0);
			chk(cmd_illegal_r, 1);
			chk(bank_state_r[23:20], 4'h4);
			ctl.issue(`DBS_CMD_RD, 5, 0);
			chk(cmd_valid_r, 1);
			ctl.issue(`DBS_CMD_PRE, 5, 0);
			chk(cmd_valid_r, 1);
			wst(5, 4'h0);
			ctl.issue(`DBS_CMD_ACT, 5, 0);
			ctl.issue(`DBS_CMD_PRE, 5, 0);
			chk(cmd_illegal_r, 1);
			wst(5, 4'h0);
			ctl.issue(`DBS_CMD_ACT, 5, 0);
			wst(5, 4'h2);
			ctl.issue(`DBS_CMD_REF, 0, 0);
			chk(cmd_illegal_r, 1);
			wst(5, 4'h0);
			$display("sequence test done");
		end
	endtask
	task t_rej;
		begin
			@(negedge core_clk);
			ctl.cke = 0;
			ctl.issue(`DBS_CMD_ACT, 3, 0);
			chk(cmd_valid_r, 0);
			ctl.cke = 1;
			ctl.issue(`DBS_CMD_NOP, 3, 0);
			chk(cmd_valid_r, 0);
			chk(bank_state_r[15:12], 4'h0);
			ctl.issue(`DBS_CMD_RD, 3, 0);
			chk(cmd_illegal_r, 1);
			self_refresh_exit = 1;
			@(negedge core_clk);
			self_refresh_exit = 0;
			ctl.issue(`DBS_CMD_ACT, 4, 0);
			chk(cmd_valid_r, 0);
			$display("refusal test done");
		end
	endtask
	task test_done;
		begin
			$display("checks %0d errors %0d", checks_done, error_cnt);
			if (error_cnt == 0 && checks_done > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	initial begin
		repeat (5) @(negedge core_clk);
		rstn = 1;
		repeat (2) @(negedge core_clk);
		t_row;
		t_all;
		t_seq;
		t_rej;
		test_done;
	end
	// Watchdog
	initial begin
		#20000;
		error_cnt = error_cnt + 1;
		test_done;
	end
endmodule

// ### dbs_ctrl_model.sv
// Controller model driving the command pins
`timescale 1ns/1ns
module dbs_ctrl_model (
	input  wire       core_clk,
	output reg        cke,
	output reg        cs_n,
	output reg        ras_n,
	output reg        cas_n,
	output reg        we_n,
	output reg  [2:0] ba,
	output reg        a10
);
	// Quiet bus at start
	initial begin
		cke = 1;
		cs_n = 1;
		{ras_n, cas_n, we_n} = 3'h7;
		ba = 3'h0;
		a10 = 0;
	end
	// One command per call, deselected with scrambled lines between
	task issue(input [2:0] op, input [2:0] b, input ap);
		begin
			@(negedge core_clk);
			cs_n = 0;
			{ras_n, cas_n, we_n} = op;
			ba = b;
			a10 = ap;
			@(negedge core_clk);
			cs_n = 1;
			{ras_n, cas_n, we_n} = ~op;
			ba = ~b;
			a10 = ~ap;
		end
	endtask
endmodule

// ### dbs_defines.vh
// Command encodings, state codes and timing constants for the bank tracker
`ifndef DBS_DEFINES_VH
`define DBS_DEFINES_VH
// Command codes {ras_n, cas_n, we_n} with chip select low
`define DBS_CMD_NOP       3'h7
`define DBS_CMD_ACT       3'h3
`define DBS_CMD_RD        3'h5
`define DBS_CMD_WR        3'h4
`define DBS_CMD_PRE       3'h2
`define DBS_CMD_REF       3'h1
`define DBS_CMD_LMR       3'h0
// Bank states
`define DBS_ST_IDLE       4'h0
`define DBS_ST_ACTV       4'h1
`define DBS_ST_ROW        4'h2
`define DBS_ST_READ       4'h3
`define DBS_ST_WRITE      4'h4
`define DBS_ST_RDAP       4'h5
`define DBS_ST_WRAP       4'h6
`define DBS_ST_PRE        4'h7
`define DBS_ST_REF        4'h8
`define DBS_ST_LMR        4'h9
`define DBS_ST_PREALL     4'hA
// Clock period in ps, interval times in ps, mode set delay and burst in cycles
`define DBS_CLK_PS        8000
`define DBS_TRP_PS        15000
`define DBS_ACTIVATE_TO_COLUMN_DELAY_PS       15000
`define DBS_REFRESH_CYCLE_TIME_PS       127500
`define DBS_MODE_SET_DELAY_CK       2
`define DBS_SELF_REFRESH_EXIT_DELAY_PS      137500
`define DBS_BURST_CK      2
// Minimum times round up to whole cycles
`define DBS_CYC(ps)       (((ps) + `DBS_CLK_PS - 1) / `DBS_CLK_PS)
`define DBS_CNT_W         8
`endif
